// file: hw/wdr_pkg.sv
// constants for the one-time-enabled watchdog with reset-out drive
// assumes sys_clk is the oscillator itself, so one clock is one oscillator period
package wdr_pkg;
    // register offsets on the special function register port
    localparam logic [7:0] AUX_CTRL_OFF = 8'h8e;
    localparam logic [7:0] RESTART_OFF = 8'ha6;
    localparam logic [7:0] STATUS_OFF = 8'ha5;

    // auxiliary control field positions
    localparam int AUX_STROBE_DISABLE_BIT = 0;
    localparam int AUX_RESET_OUT_DISABLE_BIT = 3;
    localparam int AUX_IDLE_HALT_BIT = 4;
    localparam logic [7:0] AUX_CTRL_RESET = 8'h00;
    localparam logic [7:0] AUX_CTRL_MASK = 8'h19;

    // status field positions
    localparam int STAT_ARMED_BIT = 0;
    localparam int STAT_POWER_DOWN_BIT = 1;
    localparam int STAT_WAKE_HOLD_BIT = 2;
    localparam int STAT_RESET_OUT_BIT = 3;

    // unlock pair written to the restart register
    localparam logic [7:0] KEY_FIRST = 8'h1e;
    localparam logic [7:0] KEY_SECOND = 8'he1;

    // watchdog counter
    localparam int CNT_W = 14;
    localparam logic [CNT_W-1:0] CNT_MAX = 14'h3fff;
    localparam logic [CNT_W-1:0] CNT_RESET = 14'h0000;

    // timing, in oscillator periods and machine cycles
    localparam int CLK_PERIOD_PS = 20000;
    localparam int OSC_PERIOD_PS = 20000;
    localparam int OSC_PER_MC = 12;
    localparam int OSC_PER_STROBE = 6;
    localparam int RESET_OUT_OSCILLATOR_PERIOD = 98;
    localparam int RESET_OUT_CYC = (RESET_OUT_OSCILLATOR_PERIOD * OSC_PERIOD_PS) / CLK_PERIOD_PS;
    localparam int RESET_IN_MC = 2;
    localparam int RESET_IN_CYC = (RESET_IN_MC * OSC_PER_MC * OSC_PERIOD_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

    localparam int PHASE_W = 4;
    localparam int PULSE_W = 7;
    localparam int RSTIN_W = 5;
endpackage

// file: hw/wdr_if.sv
// carrier between the watchdog control logic, its counter and its reset-out timer
// assumes all three sit on the same sys_clk
`timescale 1ns/1ps
interface wdr_if;
    logic mc_tick;
    logic cnt_armed;
    logic cnt_halt;
    logic cnt_clear;
    logic cnt_overflow;
    logic pulse_start;
    logic pulse_active;

    modport ctl (output mc_tick, output cnt_armed, output cnt_halt, output cnt_clear,
                 input cnt_overflow, output pulse_start, input pulse_active);
    modport ctr (input mc_tick, input cnt_armed, input cnt_halt, input cnt_clear,
                 output cnt_overflow);
    modport pls (input pulse_start, output pulse_active);
endinterface

// file: hw/wdr_counter.sv
// 14-bit watchdog counter, one step per machine cycle
// assumes the control logic supplies the machine-cycle tick and the halt conditions
`timescale 1ns/1ps
module wdr_counter (
    input wire logic sys_clk,
    input wire logic arst_n,
    wdr_if.ctr bus
);
    logic [wdr_pkg::CNT_W-1:0] cnt_q;
    logic [wdr_pkg::CNT_W-1:0] cnt_d;
    logic ovf_q;
    logic ovf_d;

    ////////////////////////////////////////////////////////////////////////////
    always_comb begin
        cnt_d = cnt_q;
        ovf_d = 1'b0;
        if (bus.cnt_clear || !bus.cnt_armed) begin
            cnt_d = wdr_pkg::CNT_RESET;
        end else if (cnt_q == wdr_pkg::CNT_MAX) begin
            // overflow fires once, count restarts; control disarms next cycle
            ovf_d = 1'b1; // R5
            cnt_d = wdr_pkg::CNT_RESET;
        end else if (bus.mc_tick && !bus.cnt_halt) begin
            cnt_d = cnt_q + 14'h0001; // R4
        end
    end

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            cnt_q <= wdr_pkg::CNT_RESET;
            ovf_q <= 1'b0;
        end else begin
            cnt_q <= cnt_d;
            ovf_q <= ovf_d;
        end
    end

    assign bus.cnt_overflow = ovf_q;
endmodule

// file: hw/wdr_rstout.sv
// reset-out pulse timer: holds the reset pin drive for a fixed oscillator count
// assumes a one-cycle start pulse; a start while busy is ignored
`timescale 1ns/1ps
module wdr_rstout (
    input wire logic sys_clk,
    input wire logic arst_n,
    wdr_if.pls bus
);
    logic [wdr_pkg::PULSE_W-1:0] left_q;
    logic [wdr_pkg::PULSE_W-1:0] left_d;
    logic active_q;
    logic active_d;

    ////////////////////////////////////////////////////////////////////////////
    always_comb begin
        left_d = left_q;
        if (bus.pulse_start && !active_q) begin
            left_d = wdr_pkg::PULSE_W'(wdr_pkg::RESET_OUT_CYC); // R8
        end else if (left_q != '0) begin
            left_d = left_q - 7'h01;
        end
        active_d = (left_d != '0);
    end

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            left_q <= '0;
            active_q <= 1'b0;
        end else begin
            left_q <= left_d;
            active_q <= active_d;
        end
    end

    assign bus.pulse_active = active_q;
endmodule

// file: hw/wdr_top.sv
// Operation
// R1: watchdog disabled after every reset
// R2: writing 1E then E1 arms it
// R3: same pair while armed clears count
// R4: armed counter steps every machine cycle
// R5: reaching 3FFF resets device and disarms
// R6: no software disable once armed
// R7: restart write-only, count never visible
// R8: overflow drives reset pin 98 oscillator periods
// R9: reset-out disable bit gates pin drive
// R10: idle-halt bit stops counting in idle
// R11: strobe disable limits strobe to moves
// R12: power-down stops oscillator, count holds
// R13: power-down left by reset or interrupt
// R14: after interrupt wake, wait pin high
// R15: software restarts in wake service routine
// R16: reset pin high two machine cycles resets
// R17: pair must be consecutive restart writes
//
// top of the watchdog block: register port, machine-cycle timing, power states,
// address-latch strobe and reset pin handling.
// assumes the cpu core reports idle, power-down entry and move instructions,
// and that the board resolves the reset pin from rst_pin_o / rst_pin_oe.
`timescale 1ns/1ps
module wdr_top (
    input wire logic sys_clk,
    input wire logic arst_n,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    input wire logic rst_pin_i,
    output logic rst_pin_o,
    output logic rst_pin_oe,
    input wire logic cpu_idle,
    input wire logic pd_enter,
    input wire logic wake_int_n,
    input wire logic wake_int_en,
    input wire logic move_active,
    output logic ale,
    output logic chip_reset
);
    wdr_if link ();

    ////////////////////////////////////////////////////////////////////////////
    // decode

    function automatic logic sel(input logic [7:0] addr, input logic [7:0] off);
        sel = (addr == off);
    endfunction

    logic wr_aux;
    logic wr_restart;
    assign wr_aux = reg_wr && sel(reg_addr, wdr_pkg::AUX_CTRL_OFF);
    assign wr_restart = reg_wr && sel(reg_addr, wdr_pkg::RESTART_OFF);

    ////////////////////////////////////////////////////////////////////////////
    // device reset sources

    logic [wdr_pkg::RSTIN_W-1:0] rstin_cnt_q;
    logic [wdr_pkg::RSTIN_W-1:0] rstin_cnt_d;
    logic pin_reset_q;
    logic pin_reset_d;
    logic chip_reset_q;
    logic chip_reset_d;
    logic soft_clr;

    // internal clear is synchronous so the pulse timer and pin logic survive it
    assign soft_clr = pin_reset_q || link.cnt_overflow; // R5

    always_comb begin
        rstin_cnt_d = rstin_cnt_q;
        pin_reset_d = 1'b0;
        if (!rst_pin_i) begin
            rstin_cnt_d = '0;
        end else if (rstin_cnt_q != wdr_pkg::RSTIN_W'(wdr_pkg::RESET_IN_CYC)) begin
            rstin_cnt_d = rstin_cnt_q + 5'h01;
        end
        // reset holds for as long as the pin stays high after qualifying
        if (rst_pin_i && rstin_cnt_d == wdr_pkg::RSTIN_W'(wdr_pkg::RESET_IN_CYC)) begin
            pin_reset_d = 1'b1; // R16
        end
        chip_reset_d = pin_reset_d || link.cnt_overflow;
    end

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            rstin_cnt_q <= '0;
            pin_reset_q <= 1'b0;
            chip_reset_q <= 1'b0;
        end else begin
            rstin_cnt_q <= rstin_cnt_d;
            pin_reset_q <= pin_reset_d;
            chip_reset_q <= chip_reset_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // power states

    typedef enum logic [1:0] {
        WDR_PWR_RUN,
        WDR_PWR_DOWN,
        WDR_PWR_WAKE_HOLD
    } wdr_pwr_t;

    wdr_pwr_t pwr_q;
    wdr_pwr_t pwr_d;
    logic osc_run;

    always_comb begin
        pwr_d = pwr_q;
        case (pwr_q)
            WDR_PWR_RUN: begin
                if (pd_enter) begin
                    pwr_d = WDR_PWR_DOWN;
                end
            end
            WDR_PWR_DOWN: begin
                // only an enabled low-level interrupt wakes; reset handled below
                if (wake_int_en && !wake_int_n) begin
                    pwr_d = WDR_PWR_WAKE_HOLD; // R13
                end
            end
            WDR_PWR_WAKE_HOLD: begin
                if (wake_int_n) begin
                    pwr_d = WDR_PWR_RUN; // R14
                end
            end
            default: begin
                pwr_d = WDR_PWR_RUN;
            end
        endcase
        if (pin_reset_q) begin
            pwr_d = WDR_PWR_RUN; // R13
        end
    end

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            pwr_q <= WDR_PWR_RUN;
        end else begin
            pwr_q <= pwr_d;
        end
    end

    // the oscillator is frozen in power-down; wake hold keeps it running
    assign osc_run = (pwr_q != WDR_PWR_DOWN); // R12

    ////////////////////////////////////////////////////////////////////////////
    // oscillator phase: machine cycle and strobe timing

    logic [wdr_pkg::PHASE_W-1:0] phase_q;
    logic [wdr_pkg::PHASE_W-1:0] phase_d;
    logic mc_tick_q;
    logic mc_tick_d;
    logic ale_q;
    logic ale_d;
    logic strobe_slot;

    always_comb begin
        phase_d = phase_q;
        mc_tick_d = 1'b0;
        if (osc_run) begin
            if (phase_q == wdr_pkg::PHASE_W'(wdr_pkg::OSC_PER_MC - 1)) begin
                phase_d = '0;
                mc_tick_d = 1'b1;
            end else begin
                phase_d = phase_q + 4'h1;
            end
        end
    end

    // two strobe slots per machine cycle give the 1/6 rate
    assign strobe_slot = osc_run &&
        (phase_q == '0 || phase_q == wdr_pkg::PHASE_W'(wdr_pkg::OSC_PER_STROBE));

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            phase_q <= '0;
            mc_tick_q <= 1'b0;
        end else begin
            phase_q <= phase_d;
            mc_tick_q <= mc_tick_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // auxiliary control register

    logic [7:0] aux_q;
    logic [7:0] aux_d;

    always_comb begin
        aux_d = aux_q;
        if (soft_clr) begin
            aux_d = wdr_pkg::AUX_CTRL_RESET;
        end else if (wr_aux) begin
            aux_d = reg_wdata & wdr_pkg::AUX_CTRL_MASK;
        end
    end

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            aux_q <= wdr_pkg::AUX_CTRL_RESET;
        end else begin
            aux_q <= aux_d;
        end
    end

    always_comb begin
        ale_d = 1'b0;
        if (strobe_slot) begin
            if (aux_q[wdr_pkg::AUX_STROBE_DISABLE_BIT]) begin
                ale_d = move_active; // R11
            end else begin
                ale_d = 1'b1; // R11
            end
        end
    end

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            ale_q <= 1'b0;
        end else begin
            ale_q <= ale_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // unlock sequence and arming

    logic armed_q;
    logic armed_d;
    logic key_half_q;
    logic key_half_d;
    logic clear_q;
    logic clear_d;
    logic key_done;

    // only restart writes move the sequence; other addresses leave it alone
    assign key_done = wr_restart && key_half_q && (reg_wdata == wdr_pkg::KEY_SECOND); // R17

    always_comb begin
        armed_d = armed_q;
        key_half_d = key_half_q;
        clear_d = 1'b0;
        if (wr_restart) begin
            key_half_d = (reg_wdata == wdr_pkg::KEY_FIRST); // R17
        end
        if (key_done) begin
            armed_d = 1'b1; // R2
            clear_d = 1'b1; // R3
        end
        // no write path clears armed; only the reset sources do
        if (soft_clr) begin
            armed_d = 1'b0; // R6
            key_half_d = 1'b0;
            clear_d = 1'b0;
        end
    end

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            armed_q <= 1'b0; // R1
            key_half_q <= 1'b0;
            clear_q <= 1'b0;
        end else begin
            armed_q <= armed_d;
            key_half_q <= key_half_d;
            clear_q <= clear_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // counter and reset-out timer

    assign link.mc_tick = mc_tick_q;
    assign link.cnt_armed = armed_q; // R1
    assign link.cnt_clear = clear_q; // R3
    assign link.cnt_halt = !osc_run || (pwr_q == WDR_PWR_WAKE_HOLD) || // R12 R14
        (cpu_idle && aux_q[wdr_pkg::AUX_IDLE_HALT_BIT]); // R10
    // the disable bit is sampled before the overflow clears the register
    assign link.pulse_start = link.cnt_overflow && !aux_q[wdr_pkg::AUX_RESET_OUT_DISABLE_BIT]; // R9

    wdr_counter u_counter (
        .sys_clk(sys_clk),
        .arst_n(arst_n),
        .bus(link)
    );

    wdr_rstout u_rstout (
        .sys_clk(sys_clk),
        .arst_n(arst_n),
        .bus(link)
    );

    ////////////////////////////////////////////////////////////////////////////
    // read port

    logic [7:0] rdata_q;
    logic [7:0] rdata_d;

    always_comb begin
        rdata_d = 8'h00; // R7
        if (reg_rd) begin
            if (sel(reg_addr, wdr_pkg::AUX_CTRL_OFF)) begin
                rdata_d = aux_q;
            end else if (sel(reg_addr, wdr_pkg::STATUS_OFF)) begin
                rdata_d[wdr_pkg::STAT_ARMED_BIT] = armed_q;
                rdata_d[wdr_pkg::STAT_POWER_DOWN_BIT] = (pwr_q == WDR_PWR_DOWN);
                rdata_d[wdr_pkg::STAT_WAKE_HOLD_BIT] = (pwr_q == WDR_PWR_WAKE_HOLD);
                rdata_d[wdr_pkg::STAT_RESET_OUT_BIT] = link.pulse_active;
            end
            // restart register and counter read as zero
            // no read path reaches the count, so software never observes it
        end
    end

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            rdata_q <= 8'h00;
        end else begin
            rdata_q <= rdata_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // outputs

    assign reg_rdata = rdata_q;
    assign rst_pin_o = link.pulse_active; // R8
    assign rst_pin_oe = link.pulse_active; // R8
    assign ale = ale_q;
    assign chip_reset = chip_reset_q;
endmodule

// file: bench/wdr_top_chk.sv
// port checker for the watchdog block top
// assumes one sys_clk domain, arst_n active low
`timescale 1ns/1ps
module wdr_top_chk (
    input wire logic sys_clk,
    input wire logic arst_n,
    input wire logic [7:0] reg_addr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_rdata,
    input wire logic rst_pin_i,
    input wire logic rst_pin_o,
    input wire logic rst_pin_oe,
    input wire logic ale,
    input wire logic chip_reset
);
    logic [7:0] oe_cnt_q, oe_cnt_d;
    logic [5:0] pin_cnt_q, pin_cnt_d;
    always_comb begin
        oe_cnt_d = rst_pin_oe ? oe_cnt_q + 8'h01 : 8'h00;
        pin_cnt_d = !rst_pin_i ? 6'h00 : (pin_cnt_q == 6'h3f ? pin_cnt_q : pin_cnt_q + 6'h01);
    end
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            oe_cnt_q <= 8'h00;
            pin_cnt_q <= 6'h00;
        end else begin
            oe_cnt_q <= oe_cnt_d;
            pin_cnt_q <= pin_cnt_d;
        end
    end
    ////////////////////////////////////////////////////////////
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!arst_n);
    AST_RD_QUIET: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00) else $error("stray read data");
    AST_WO_READ: assert property ($past(reg_rd) && $past(reg_addr) == wdr_pkg::RESTART_OFF
        |-> reg_rdata == 8'h00) else $error("restart register readable");
    AST_AUX_BITS: assert property ($past(reg_rd) && $past(reg_addr) == wdr_pkg::AUX_CTRL_OFF
        |-> (reg_rdata & ~wdr_pkg::AUX_CTRL_MASK) == 8'h00) else $error("reserved aux bits set");
    AST_OE_DRIVE: assert property (rst_pin_oe |-> rst_pin_o) else $error("pin enabled low");
    AST_OE_START: assert property ($rose(rst_pin_oe) |-> chip_reset) else $error("drive without reset");
    AST_OE_MAX: assert property (oe_cnt_q <= 8'h62) else $error("pin drive too long");
    AST_OE_LEN: assert property ($fell(rst_pin_oe) && oe_cnt_q != 8'h00 |-> oe_cnt_q == 8'h62)
        else $error("pin drive length wrong");
    // pin reset keeps chip_reset up, so only a quiet pin proves the pulse
    AST_OVF_ONE: assert property (chip_reset && !rst_pin_i && !$past(rst_pin_i) && !$past(rst_pin_i, 2)
        |=> !chip_reset) else $error("overflow reset too long");
    AST_ALE_GAP: assert property (ale |=> !ale [*5]) else $error("strobe too fast");
    // 24 consecutive high samples qualify, so the 25th sees chip_reset up
    AST_PIN_RST: assert property (rst_pin_i && pin_cnt_q >= 6'h18 |-> chip_reset)
        else $error("pin reset missed");
    cover property ($fell(rst_pin_oe) && oe_cnt_q == 8'h62);
    cover property (rst_pin_i && pin_cnt_q >= 6'h18);
    cover property ($past(reg_rd) && reg_rdata != 8'h00);
endmodule
bind wdr_top wdr_top_chk wdr_top_chk_inst (.sys_clk(sys_clk), .arst_n(arst_n), .reg_addr(reg_addr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .rst_pin_i(rst_pin_i), .rst_pin_o(rst_pin_o),
    .rst_pin_oe(rst_pin_oe), .ale(ale), .chip_reset(chip_reset));

// file: bench/wdr_top_tb_top.sv
// self-checking bench for the watchdog block top
// assumes the bench owns the reset pin level; the drive is not looped back
`timescale 1ns/1ps
`define CK(a, b) begin total_checks++; if ((a) !== (b)) begin bad_count++; \
    $display("CHECK FAILED t=%0t got %h exp %h", $time, (a), (b)); end end
module wdr_top_tb_top;
    localparam logic [7:0] aux_a = wdr_pkg::AUX_CTRL_OFF;
    localparam logic [7:0] rst_a = wdr_pkg::RESTART_OFF;
    localparam logic [7:0] st_a = wdr_pkg::STATUS_OFF;
    localparam int full_cyc = 16383 * 12;
    logic sys_clk, arst_n, reg_wr, reg_rd, rst_pin_i, rst_pin_o, rst_pin_oe, cpu_idle, pd_enter;
    logic wake_int_n, wake_int_en, move_active, ale, chip_reset;
    logic [7:0] reg_addr, reg_wdata, reg_rdata, d;
    int bad_count = 0;
    int total_checks = 0;
    int k;
    wdr_top wdr_top_inst (.sys_clk(sys_clk), .arst_n(arst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .rst_pin_i(rst_pin_i), .rst_pin_o(rst_pin_o),
        .rst_pin_oe(rst_pin_oe), .cpu_idle(cpu_idle), .pd_enter(pd_enter), .wake_int_n(wake_int_n),
        .wake_int_en(wake_int_en), .move_active(move_active), .ale(ale), .chip_reset(chip_reset));
    always #10 sys_clk = ~sys_clk;
    ////////////////////////////////////////////////////////////
    task automatic cyc(input int n);
        repeat (n) @(posedge sys_clk);
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        @(posedge sys_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= v;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a);
        @(posedge sys_clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        #1 d = reg_rdata;
    endtask
    // counts strobes over ten slots, returns on an edge
    task automatic ale_n(output int n);
        n = 0;
        repeat (60) begin
            @(posedge sys_clk);
            #1 if (ale === 1'b1) n++;
        end
        @(posedge sys_clk);
    endtask
    // bounded wait; a timeout ends the run
    task automatic wait_rst(input int lim);
        k = 0;
        while (chip_reset !== 1'b1 && k < lim) begin
            @(posedge sys_clk);
            #1 k++;
        end
        if (k >= lim) begin
            bad_count++;
            results();
        end
    endtask
    ////////////////////////////////////////////////////////////
    task automatic t_reset;
        rd(aux_a);
        `CK(d, 8'h00)
        rd(st_a);
        `CK(d[0], 1'b0)
        rd(rst_a);
        `CK(d, 8'h00)
        rd(8'h00);
        `CK(d, 8'h00)
    endtask
    task automatic t_aux;
        wr(aux_a, 8'hff);
        rd(aux_a);
        `CK(d, 8'h19)
        wr(aux_a, 8'h01);
        ale_n(k);
        `CK(k, 0)
        move_active <= 1'b1;
        ale_n(k);
        `CK(k, 10)
        move_active <= 1'b0;
        wr(aux_a, 8'h00);
        ale_n(k);
        `CK(k, 10)
    endtask
    task automatic t_arm;
        wr(rst_a, 8'h1e);
        wr(rst_a, 8'h55);
        wr(rst_a, 8'he1);
        rd(st_a);
        `CK(d[0], 1'b0)
        wr(rst_a, 8'h1e);
        wr(aux_a, 8'h00);
        wr(rst_a, 8'he1);
        rd(st_a);
        `CK(d[0], 1'b1)
        wr(rst_a, 8'h00);
        wr(aux_a, 8'h00);
        rd(st_a);
        `CK(d[0], 1'b1)
    endtask
    // halted time is excluded from the run to overflow after servicing
    task automatic t_ovf;
        time t0;
        int h;
        wr(aux_a, 8'h10);
        cyc(300);
        wr(rst_a, 8'h1e);
        wr(rst_a, 8'he1);
        t0 = $time;
        cpu_idle <= 1'b1;
        cyc(400);
        cpu_idle <= 1'b0;
        pd_enter <= 1'b1;
        cyc(1);
        pd_enter <= 1'b0;
        wake_int_n <= 1'b0;
        cyc(100);
        rd(st_a);
        `CK(d[1], 1'b1)
        ale_n(k);
        `CK(k, 0)
        wake_int_en <= 1'b1;
        cyc(100);
        rd(st_a);
        `CK(d[2:1], 2'b10)
        @(posedge sys_clk);
        wake_int_n <= 1'b1;
        wake_int_en <= 1'b0;
        h = int'(($time - t0) / 20);
        wait_rst(full_cyc + 100);
        h = int'(($time - t0) / 20) - h;
        `CK(h > full_cyc - 24 && h < full_cyc + 24, 1'b1)
        `CK(rst_pin_oe, 1'b1)
        k = 0;
        while (rst_pin_oe === 1'b1 && k < 200) begin
            k++;
            @(posedge sys_clk);
            #1;
        end
        `CK(k, 98)
        rd(st_a);
        `CK(d[0], 1'b0)
    endtask
    task automatic t_pin;
        wr(rst_a, 8'h1e);
        wr(rst_a, 8'he1);
        wr(aux_a, 8'h19);
        // short power-down, wake by interrupt, then service as the wake handler would
        pd_enter <= 1'b1;
        cyc(1);
        pd_enter <= 1'b0;
        wake_int_en <= 1'b1;
        wake_int_n <= 1'b0;
        cyc(3);
        wake_int_n <= 1'b1;
        wake_int_en <= 1'b0;
        wr(rst_a, 8'h1e);
        wr(rst_a, 8'he1);
        rd(st_a);
        `CK(d[2:0], 3'b001)
        rst_pin_i <= 1'b1;
        wait_rst(40);
        `CK(k >= 24, 1'b1)
        @(posedge sys_clk);
        rst_pin_i <= 1'b0;
        cyc(3);
        rd(st_a);
        `CK(d[0], 1'b0)
        rd(aux_a);
        `CK(d, 8'h00)
    endtask
    task automatic results;
        $display("checks %0d mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    ////////////////////////////////////////////////////////////
    initial begin
        sys_clk = 1'b0;
        arst_n = 1'b0;
        {reg_wr, reg_rd, rst_pin_i, cpu_idle, pd_enter, wake_int_en, move_active} = 7'h00;
        wake_int_n = 1'b1;
        reg_addr = 8'h00;
        reg_wdata = 8'h00;
        cyc(6);
        arst_n <= 1'b1;
        t_reset();
        t_aux();
        t_arm();
        t_ovf();
        t_pin();
        results();
    end
endmodule
